// ### hw/csfp_pkg.sv
// Shared constants and link record for cadence sync and mobile frame tracking
package csfp_pkg;
    localparam int unsigned P_W = 10;
    localparam int unsigned F_W = 5;
    localparam int unsigned M_W = 14;
    localparam int unsigned T_W = 12;
    localparam int unsigned NTIERS = 4;
    localparam logic [P_W-1:0] FRM_PKTS = 10'h270;
    localparam logic [P_W-1:0] FRM_LAST = 10'h26F;
    localparam logic [P_W-1:0] MH_OFS = 10'h025;
    localparam logic [P_W-1:0] PERIOD_IDX = 10'h24B;
    localparam logic [F_W-1:0] FRAME_LAST = 5'h13;
    localparam logic [14:0] MHF_PKTS = 15'h30C0;
    localparam logic [M_W-1:0] MHF_LAST = 14'h30BF;
    localparam logic [T_W-1:0] TR_SEED = 12'hA53;
    localparam logic [T_W-1:0] TR_TAPS = 12'h829;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OFS = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] OFS_RST = 32'h0000_0000;
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_TIER = 1;
    localparam int unsigned CTRL_MODE = 3;
    localparam int unsigned CTRL_POS = 5;
    localparam int unsigned OFS_UNIT = 16;

    typedef struct packed {
        logic           pkt_valid;
        logic           ctrl_valid;
        logic [P_W-1:0] pkt_num;
        logic [F_W-1:0] frame_num;
        logic [1:0]     tier;
        logic [7:0]     unit_id;
        logic [15:0]    time_offset;
        logic [31:0]    release_stamp;
        logic [T_W-1:0] trellis;
        logic           trellis_par;
        logic           fss_valid;
        logic [1:0]     fss_mode;
        logic           side_mhf;
    } csfp_link_s;
endpackage

// ### hw/csfp_link_if.sv
// Packet stream link between adapter and slave synchronizer
`timescale 1ns/1ns
`default_nettype none
interface csfp_link_if
    import csfp_pkg::*;
(
    input wire logic aclk
);
    csfp_link_s bus;

    modport adapter (input aclk, output bus);
    modport device (input aclk, input bus);
endinterface
`default_nettype wire

// ### hw/csfp_adapter.sv
// Transmission adapter end: cadence counting, tier control packets, register slave
`timescale 1ns/1ns
`default_nettype none
module csfp_adapter
    import csfp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        pkt_tick,
    csfp_link_if.adapter     lnk,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic           awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]     bresp_q, rresp_q;
    logic [31:0]    rdata_q, wdata_q, ctrl_q, ofs_q;
    logic [3:0]     awaddr_q, wstrb_q;
    logic [P_W-1:0] p_q;
    logic [F_W-1:0] f_q;
    logic [31:0]    time_q;
    logic [T_W-1:0] tr_q [NTIERS];
    csfp_link_s     lnk_q;

    wire            aw_take = s_axi_awvalid & awready_q;
    wire            w_take  = s_axi_wvalid & wready_q;
    wire            wr_go   = ~awready_q & ~wready_q & ~bvalid_q;
    wire            wr_ctrl = wr_go & (awaddr_q == ADDR_CTRL);
    wire            wr_ofs  = wr_go & (awaddr_q == ADDR_OFS);
    wire            wr_hit  = (awaddr_q == ADDR_CTRL) | (awaddr_q == ADDR_OFS);
    wire            rd_hit  = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_OFS)
                              | (s_axi_araddr == ADDR_STAT);
    wire [31:0]     stat_w  = {17'h0_0000, f_q, p_q};
    wire [31:0]     rd_mux  = (s_axi_araddr == ADDR_CTRL) ? ctrl_q :
                              (s_axi_araddr == ADDR_OFS) ? ofs_q :
                              (s_axi_araddr == ADDR_STAT) ? stat_w : 32'h0000_0000;

    wire            step    = ce & pkt_tick & ctrl_q[CTRL_EN];
    wire            p_wrap  = (p_q == FRM_LAST);
    wire [1:0]      tiers_m1 = ctrl_q[CTRL_TIER +: 2];
    wire [P_W-1:0]  cpos    = ctrl_q[CTRL_POS +: P_W];
    wire [P_W-1:0]  rel     = p_q - cpos;
    wire            is_ctrl = (p_q >= cpos) & (rel <= {8'h00, tiers_m1});
    wire [1:0]      tsel    = rel[1:0];

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign lnk.bus       = lnk_q;

    // Write channel: address and data taken in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            awaddr_q  <= 4'h0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else if (ce) begin
            if (aw_take) begin
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (w_take) begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q & s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Register store with byte enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            ofs_q  <= OFS_RST;
        end else if (ce) begin
            for (int b = 0; b < 4; b++) begin
                if (wr_ctrl & wstrb_q[b]) ctrl_q[8*b +: 8] <= wdata_q[8*b +: 8];
                if (wr_ofs & wstrb_q[b]) ofs_q[8*b +: 8] <= wdata_q[8*b +: 8];
            end
        end
    end

    // Read channel: data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid & arready_q) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_mux;
                rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q & s_axi_rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // Master cadence: packet index wraps at each cadence point
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p_q    <= '0;
            f_q    <= '0;
            time_q <= 32'h0000_0000;
        end else if (step) begin
            p_q    <= p_wrap ? '0 : p_q + 10'h001;
            time_q <= time_q + 32'h0000_0001;
            if (p_wrap) f_q <= (f_q == FRAME_LAST) ? '0 : f_q + 5'h01;
        end
    end

    // Per-tier models reload their trellis reference at each cadence point
    for (genvar t = 0; t < NTIERS; t++) begin : g_tier
        localparam logic [T_W-1:0] SEED = TR_SEED ^ T_W'(t);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                tr_q[t] <= SEED;
            end else if (step) begin
                tr_q[t] <= p_wrap ? SEED : {tr_q[t][T_W-2:0], ^(tr_q[t] & TR_TAPS)};
            end
        end
    end

    // Link beat for each packet tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lnk_q <= '0;
        end else if (ce) begin
            lnk_q.pkt_valid  <= step;
            lnk_q.ctrl_valid <= step & is_ctrl;
            lnk_q.fss_valid  <= step & (p_q == '0);
            if (step) begin
                lnk_q.pkt_num       <= p_q;
                lnk_q.frame_num     <= f_q;
                lnk_q.tier          <= tsel;
                lnk_q.unit_id       <= ofs_q[OFS_UNIT +: 8];
                lnk_q.time_offset   <= ofs_q[15:0];
                lnk_q.release_stamp <= time_q + 32'(FRM_PKTS - p_q);
                lnk_q.trellis       <= tr_q[tsel];
                lnk_q.trellis_par   <= ^tr_q[tsel];
                lnk_q.fss_mode      <= ctrl_q[CTRL_MODE +: 2];
                lnk_q.side_mhf      <= (f_q == FRAME_LAST) & (p_q == PERIOD_IDX);
            end
        end
    end
endmodule
`default_nettype wire

// ### hw/csfp_slave_sync.sv
// Slave synchronizer end: cadence, frame boundary, trellis and mode tracking
`timescale 1ns/1ns
`default_nettype none
module csfp_slave_sync
    import csfp_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    csfp_link_if.device     lnk,
    input  wire logic [1:0] own_tier,
    input  wire logic [7:0] own_unit,
    input  wire logic       use_side,
    output logic            fss_insert,
    output logic            proc_restart,
    output logic            period_start,
    output logic            mhf_start,
    output logic            locked,
    output logic            mhf_locked,
    output logic [P_W-1:0]  prev_csp_dist,
    output logic [P_W-1:0]  next_csp_dist,
    output logic [M_W-1:0]  prev_mhf_dist,
    output logic [M_W-1:0]  next_mhf_dist,
    output logic            trellis_load,
    output logic [T_W-1:0]  trellis_state,
    output logic            trellis_err,
    output logic [1:0]      out_mode,
    output logic [15:0]     emit_offset,
    output logic [31:0]     csp_release
);
    logic           lock_q;
    logic           mlock_q;
    logic [P_W-1:0] lp_q;
    logic [M_W-1:0] mp_q;
    logic           fss_q;
    logic           restart_q;
    logic           period_q;
    logic           mhf_q;
    logic [P_W-1:0] prev_csp_q;
    logic [P_W-1:0] next_csp_q;
    logic [M_W-1:0] prev_mhf_q;
    logic [M_W-1:0] next_mhf_q;
    logic           tr_pend_q;
    logic [T_W-1:0] tr_hold_q;
    logic           tr_load_q;
    logic [T_W-1:0] tr_state_q;
    logic           tr_err_q;
    logic [1:0]     mode_q;
    logic [15:0]    emit_q;
    logic [31:0]    stamp_q;
    logic [31:0]    release_q;

    csfp_link_s     b;
    assign b = lnk.bus;

    // Packet beat and own-tier control packet selection
    wire            rx       = ce & b.pkt_valid;
    wire            accept   = rx & b.ctrl_valid & (b.tier == own_tier);
    wire            par_ok   = ~^{b.trellis, b.trellis_par};
    wire            unit_hit = rx & b.ctrl_valid & (b.unit_id == own_unit);

    // Cadence position of the current packet
    wire [P_W-1:0]  idx_inc  = (lp_q == FRM_LAST) ? '0 : lp_q + 10'h001;
    wire [P_W-1:0]  idx      = accept ? b.pkt_num : idx_inc;
    wire            lock_d   = lock_q | accept;
    wire            slip     = accept & lock_q & (b.pkt_num != idx_inc);
    wire            csp_now  = lock_d & (idx == '0);
    wire            per_now  = lock_d & (idx == PERIOD_IDX);

    // Cadence distances around the carrying packet
    wire [P_W-1:0]  csp_prev = b.pkt_num;
    wire [P_W-1:0]  csp_next = FRM_PKTS - b.pkt_num;

    // Mobile frame position from packet and frame index
    wire [14:0]     mh_sum   = 15'(b.frame_num) * 15'(FRM_PKTS)
                               + 15'(b.pkt_num) + 15'(MH_OFS);
    wire [M_W-1:0]  mh_mod   = (mh_sum >= MHF_PKTS) ? M_W'(mh_sum - MHF_PKTS)
                                                    : mh_sum[M_W-1:0];
    wire [M_W-1:0]  mh_next  = M_W'(MHF_PKTS - 15'(mh_mod));
    wire [M_W-1:0]  mp_inc   = (mp_q == MHF_LAST) ? '0 : mp_q + 14'h0001;
    wire [M_W-1:0]  mp_ctl   = accept ? mh_mod : mp_inc;
    wire [M_W-1:0]  mp_side  = b.side_mhf ? '0 : mp_inc;
    wire [M_W-1:0]  mpos     = use_side ? mp_side : mp_ctl;
    wire            mlock_d  = mlock_q | (use_side ? b.side_mhf : accept);
    wire            mhf_now  = mlock_d & (mpos == '0);

    // Trellis load source at a cadence point
    wire            csp_beat = rx & csp_now;
    wire            tr_good  = accept & par_ok;
    wire            tr_old   = csp_beat & tr_pend_q & ~tr_good;
    wire            tr_new   = csp_beat & tr_good;

    assign fss_insert    = fss_q;
    assign proc_restart  = restart_q;
    assign period_start  = period_q;
    assign mhf_start     = mhf_q;
    assign locked        = lock_q;
    assign mhf_locked    = mlock_q;
    assign prev_csp_dist = prev_csp_q;
    assign next_csp_dist = next_csp_q;
    assign prev_mhf_dist = prev_mhf_q;
    assign next_mhf_dist = next_mhf_q;
    assign trellis_load  = tr_load_q;
    assign trellis_state = tr_state_q;
    assign trellis_err   = tr_err_q;
    assign out_mode      = mode_q;
    assign emit_offset   = emit_q;
    assign csp_release   = release_q;

    // Position counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_q  <= 1'b0;
            mlock_q <= 1'b0;
            lp_q    <= '0;
            mp_q    <= '0;
        end else if (rx) begin
            lock_q  <= lock_d;
            mlock_q <= mlock_d;
            lp_q    <= idx;
            mp_q    <= mpos;
        end
    end

    // Cadence and boundary strobes, one cycle each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fss_q     <= 1'b0;
            restart_q <= 1'b0;
            period_q  <= 1'b0;
            mhf_q     <= 1'b0;
        end else if (ce) begin
            fss_q     <= rx & csp_now;
            restart_q <= rx & (csp_now | slip);
            period_q  <= rx & per_now;
            mhf_q     <= rx & mhf_now;
        end
    end

    // Distances seen from the last own-tier control packet
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_csp_q <= '0;
            next_csp_q <= '0;
            prev_mhf_q <= '0;
            next_mhf_q <= '0;
        end else if (accept) begin
            prev_csp_q <= csp_prev;
            next_csp_q <= csp_next;
            prev_mhf_q <= mh_mod;
            next_mhf_q <= mh_next;
        end
    end

    // Trellis reference held until the next cadence point
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tr_pend_q <= 1'b0;
            tr_hold_q <= '0;
            tr_err_q  <= 1'b0;
        end else if (ce) begin
            if (accept) tr_err_q <= ~par_ok;
            if (tr_good) begin
                tr_pend_q <= ~csp_now;
                tr_hold_q <= b.trellis;
            end else if (csp_beat) begin
                tr_pend_q <= 1'b0;
            end
        end
    end

    // Trellis load at the cadence point
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tr_load_q  <= 1'b0;
            tr_state_q <= '0;
        end else if (ce) begin
            tr_load_q <= tr_old | tr_new;
            if (tr_old) begin
                tr_state_q <= tr_hold_q;
            end else if (tr_new) begin
                tr_state_q <= b.trellis;
            end
        end
    end

    // Mode and emission offset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= 2'h0;
            emit_q <= 16'h0000;
        end else if (ce) begin
            if (rx & b.fss_valid) mode_q <= b.fss_mode;
            if (unit_hit) emit_q <= b.time_offset;
        end
    end

    // Release stamp of the next cadence point
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stamp_q   <= 32'h0000_0000;
            release_q <= 32'h0000_0000;
        end else if (ce) begin
            if (accept) stamp_q <= b.release_stamp;
            if (csp_beat) begin
                release_q <= accept ? b.release_stamp : stamp_q;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/csfp_checker.sv
// Concurrent checks on the link and on the synchronizer outputs
`timescale 1ns/1ns
`default_nettype none
module csfp_checker
    import csfp_pkg::*;
(
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire csfp_link_s     bus,
    input wire logic [1:0]     own_tier,
    input wire logic [7:0]     own_unit,
    input wire logic           use_side,
    input wire logic           fss_insert,
    input wire logic           proc_restart,
    input wire logic           period_start,
    input wire logic           mhf_start,
    input wire logic           locked,
    input wire logic           mhf_locked,
    input wire logic [P_W-1:0] prev_csp_dist,
    input wire logic [P_W-1:0] next_csp_dist,
    input wire logic [M_W-1:0] prev_mhf_dist,
    input wire logic [M_W-1:0] next_mhf_dist,
    input wire logic           trellis_load,
    input wire logic [1:0]     out_mode,
    input wire logic [15:0]    emit_offset,
    input wire logic [31:0]    csp_release
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_beat;
        bus.pkt_valid;
    endsequence
    sequence s_own_ctrl;
        bus.pkt_valid && bus.ctrl_valid && bus.tier == own_tier && !use_side;
    endsequence
    sequence s_pulse_once;
        fss_insert ##1 !fss_insert;
    endsequence

    a_fss_at_zero: assert property (s_beat ##0 (bus.pkt_num == 0 && locked) |=> s_pulse_once)
        else $error("field sync insert missing at packet zero");
    a_fss_cause: assert property (fss_insert |-> $past(bus.pkt_valid) && $past(bus.pkt_num) == 0)
        else $error("field sync insert away from packet zero");
    a_restart_csp: assert property (fss_insert |-> proc_restart)
        else $error("no restart at cadence point");
    a_csp_dist: assert property (s_own_ctrl |=> prev_csp_dist == $past(bus.pkt_num)
        && next_csp_dist == 10'd624 - $past(bus.pkt_num))
        else $error("cadence distances wrong");
    a_mhf_prev: assert property (s_own_ctrl |=> int'(prev_mhf_dist) == (int'($past(bus.frame_num))
        * 624 + int'($past(bus.pkt_num)) + 37) % 12480)
        else $error("previous frame boundary distance wrong");
    a_mhf_next: assert property (s_own_ctrl |=> int'(next_mhf_dist) == 12480 - int'(prev_mhf_dist))
        else $error("next frame boundary distance wrong");
    a_period_pos: assert property (period_start && $past(locked) |-> $past(bus.pkt_num) == 10'd587)
        else $error("period start not 37 packets before cadence");
    a_mhf_pos: assert property (mhf_start && $past(mhf_locked) |-> $past(bus.pkt_num) == 10'd587
        && $past(bus.frame_num) == 5'd19)
        else $error("frame start at wrong packet");
    a_mode_follow: assert property (s_beat ##0 bus.fss_valid |=> out_mode == $past(bus.fss_mode))
        else $error("output mode not taken from field sync");
    a_offset_own: assert property (s_beat ##0 (bus.ctrl_valid && bus.unit_id == own_unit)
        |=> emit_offset == $past(bus.time_offset))
        else $error("own time offset not applied");
    a_trellis_csp: assert property (trellis_load |-> fss_insert)
        else $error("trellis load away from cadence point");
    a_release_csp: assert property ($changed(csp_release) |-> fss_insert)
        else $error("release stamp changed away from cadence point");
endmodule
`default_nettype wire

// ### test/test_cadence_frame_position_sync.sv
// Top testbench: adapter and synchronizer joined by the link, driven over AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
module test_cadence_frame_position_sync
    import csfp_pkg::*;
;
    logic             aclk = 1'b0;
    logic             aresetn = 1'b0;
    logic             pkt_tick = 1'b0;
    logic [3:0]       awaddr = 4'h0, araddr = 4'h0;
    logic [31:0]      wdata = 32'h0000_0000, rdata;
    logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic             awready, wready, bvalid, arready, rvalid;
    logic [1:0]       bresp, rresp, out_mode;
    logic [1:0]       own_tier = 2'h0;
    logic [7:0]       own_unit = 8'h00;
    logic             use_side = 1'b0;
    logic             ce = 1'b1;
    logic             fss_insert, proc_restart, period_start, mhf_start, locked, mhf_locked;
    logic             trellis_load, trellis_err;
    logic [T_W-1:0]   trellis_state;
    logic [P_W-1:0]   prev_csp_dist, next_csp_dist;
    logic [M_W-1:0]   prev_mhf_dist, next_mhf_dist;
    logic [15:0]      emit_offset;
    logic [31:0]      csp_release;
    logic [3:0]       ev;
    int               n_fail = 0;
    int               tests_run = 0;
    int               cyc = 0;
    int               beats = 0;

    assign ev = {mhf_locked, locked, mhf_start, fss_insert};

    csfp_link_if lnk (.aclk(aclk));
    csfp_adapter i_csfp_adapter (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pkt_tick(pkt_tick),
        .lnk(lnk.adapter), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    csfp_slave_sync i_csfp_slave_sync (.aclk(aclk), .aresetn(aresetn), .ce(ce), .lnk(lnk.device),
        .own_tier(own_tier), .own_unit(own_unit), .use_side(use_side), .fss_insert(fss_insert),
        .proc_restart(proc_restart), .period_start(period_start), .mhf_start(mhf_start),
        .locked(locked), .mhf_locked(mhf_locked), .prev_csp_dist(prev_csp_dist),
        .next_csp_dist(next_csp_dist), .prev_mhf_dist(prev_mhf_dist),
        .next_mhf_dist(next_mhf_dist), .trellis_load(trellis_load), .trellis_state(trellis_state),
        .trellis_err(trellis_err), .out_mode(out_mode), .emit_offset(emit_offset),
        .csp_release(csp_release));
    csfp_checker i_csfp_checker (.aclk(aclk), .aresetn(aresetn), .bus(lnk.bus), .own_tier(own_tier),
        .own_unit(own_unit), .use_side(use_side), .fss_insert(fss_insert),
        .proc_restart(proc_restart), .period_start(period_start), .mhf_start(mhf_start),
        .locked(locked), .mhf_locked(mhf_locked), .prev_csp_dist(prev_csp_dist),
        .next_csp_dist(next_csp_dist), .prev_mhf_dist(prev_mhf_dist),
        .next_mhf_dist(next_mhf_dist), .trellis_load(trellis_load), .out_mode(out_mode),
        .emit_offset(emit_offset), .csp_release(csp_release));

    initial begin
        forever #25 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic conclude();
        $display("Counts: %0d compared, %0d mismatched", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        check("bresp", 32'(er), 32'(bresp));
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        check("rdata", ed, rdata);
        check("rresp", 32'(er), 32'(rresp));
        @(posedge aclk);
    endtask

    function automatic logic [T_W-1:0] tr_ref(input int t, input int n);
        logic [T_W-1:0] s;
        s = TR_SEED ^ T_W'(t);
        for (int i = 0; i < n; i++) s = {s[T_W-2:0], ^(s & TR_TAPS)};
        return s;
    endfunction

    task automatic wait_ev(input int idx, input int lim, output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (ev[idx] !== 1'b1 && n < lim);
    endtask

    task automatic t_regs();
        axi_read(ADDR_CTRL, CTRL_RST, RESP_OKAY);
        axi_read(ADDR_OFS, OFS_RST, RESP_OKAY);
        axi_write(4'hC, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_read(4'hC, 32'h0000_0000, RESP_SLVERR);
        axi_write(ADDR_STAT, 32'h0000_0001, RESP_SLVERR);
        axi_write(ADDR_OFS, 32'h005A_1234, RESP_OKAY);
        axi_read(ADDR_OFS, 32'h005A_1234, RESP_OKAY);
        $display("Test registers done");
    endtask

    task automatic t_lock();
        int n;
        own_tier <= 2'h1;
        own_unit <= 8'h5A;
        axi_write(ADDR_CTRL, 32'h0000_0C93, RESP_OKAY);
        axi_read(ADDR_CTRL, 32'h0000_0C93, RESP_OKAY);
        pkt_tick <= 1'b1;
        wait_ev(2, 2000, n);
        check("locked", 32'h0000_0001, 32'(locked));
        wait_ev(0, 1000, n);
        check("release stamp", 32'(beats - 1), csp_release);
        wait_ev(0, 1000, n);
        check("cadence spacing", 32'(FRM_PKTS), 32'(n));
        check("trellis", 32'(tr_ref(1, 101)), 32'(trellis_state));
        check("trellis err", 32'h0000_0000, 32'(trellis_err));
        check("prev csp", 32'h0000_0065, 32'(prev_csp_dist));
        check("next csp", 32'h0000_020B, 32'(next_csp_dist));
        check("mode", 32'h0000_0002, 32'(out_mode));
        check("offset", 32'h0000_1234, 32'(emit_offset));
        $display("Test lock done");
    endtask

    task automatic t_tier();
        int n;
        own_tier <= 2'h0;
        wait_ev(0, 1000, n);
        wait_ev(0, 1000, n);
        check("prev csp tier0", 32'h0000_0064, 32'(prev_csp_dist));
        check("next csp tier0", 32'h0000_020C, 32'(next_csp_dist));
        own_tier <= 2'h2;
        axi_write(ADDR_CTRL, 32'h0000_1913, RESP_OKAY);
        wait_ev(0, 1000, n);
        wait_ev(0, 1000, n);
        check("prev csp other tier", 32'h0000_0064, 32'(prev_csp_dist));
        own_tier <= 2'h1;
        $display("Test tiers done");
    endtask

    task automatic t_freeze();
        int n;
        wait_ev(0, 1000, n);
        ce <= 1'b0;
        repeat (50) @(posedge aclk);
        ce <= 1'b1;
        wait_ev(0, 1000, n);
        check("frozen spacing", 32'(FRM_PKTS), 32'(n));
        $display("Test freeze done");
    endtask

    task automatic t_mhf();
        int n;
        wait_ev(3, 13000, n);
        check("mhf locked", 32'h0000_0001, 32'(mhf_locked));
        wait_ev(1, 13000, n);
        wait_ev(1, 13000, n);
        check("mhf spacing", 32'(MHF_PKTS), 32'(n));
        wait_ev(0, 1000, n);
        check("mhf to cadence", 32'(MH_OFS), 32'(n));
        use_side <= 1'b1;
        wait_ev(1, 13000, n);
        wait_ev(1, 13000, n);
        check("side mhf spacing", 32'(MHF_PKTS), 32'(n));
        $display("Test mobile frame done");
    endtask

    always @(posedge aclk) begin
        if (ce && lnk.bus.pkt_valid) beats <= beats + 1;
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_lock();
        t_tier();
        t_freeze();
        t_mhf();
        conclude();
    end
endmodule
`default_nettype wire
